// file: dv/bridge_lock_and_syserr_tb.sv
// Self-checking bench for the lock and system-error block.
// Assumes the far side model answers locked reads; other inputs come from here.
`timescale 1ns/10ps
module bridge_lock_and_syserr_tb;
  import bridge_pkg::*;
  logic       mclk, rst, awv, wv, brdy, arv, rrdy, sec_n, pw_ta, pw_ma, mto, rty;
  logic       p_lock_n, p_frame_n, lrd_req, at_head, f_hold, f_abort, pw_pend, pw_end;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [1:0] kind;
  wire        o_awr, o_wr, o_bv, o_arr, o_rv, o_serr_n, o_serr_oe_n, o_disc, o_retry_x;
  wire        o_bus_req, o_tabort, o_no_pf, o_sl_n, o_sl_oe_n, s_lock_n, s_frame_n, s_irdy_n;
  wire        lrd_done, lrd_abort;
  wire [31:0] o_rdata;
  wire [1:0]  o_bresp, o_rresp;
  int         failures, n_compared, cyc;
  localparam int LIM = 4; // Short retry limit keeps the run brief.
  always #5 mclk = ~mclk;
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic check(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic complete_run();
    $display("failures %0d compared %0d", failures, n_compared);
    if (failures == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Write one word; address and data go out together.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge mclk);
    {awaddr, wdata, awv, wv, brdy} <= {a, d, 3'h7};
    do @(posedge mclk); while (o_awr !== 1'b1 && ++t < 40);
    check(o_wr === 1'b1, "write data not taken with address");
    {awv, wv} <= 2'h0;
    do @(posedge mclk); while (o_bv !== 1'b1 && ++t < 40);
    brdy <= 1'b0;
    check(t < 40 && o_bresp === (a > OFS_LOCKSTAT ? RESP_SLVERR : RESP_OKAY), "write response");
  endtask
  // Read one word; data and response are taken at the valid edge.
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int t;
    t = 0;
    @(posedge mclk);
    {araddr, arv, rrdy} <= {a, 2'h3};
    do @(posedge mclk); while (o_rv !== 1'b1 && ++t < 40);
    {d, r} = {o_rdata, o_rresp};
    {arv, rrdy} <= 2'h0;
    check(t < 40 && o_arr === 1'b1, "read hung");
  endtask
  // Raise one cause for a cycle, then judge pulse, reason and status.
  task automatic cause(input int ev, input logic exp);
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge mclk);
    {sec_n, pw_ta, pw_ma, mto} <= {ev != EV_SEC, ev == EV_PWTA, ev == EV_PWMA, ev == EV_MTO};
    @(posedge mclk);
    {sec_n, pw_ta, pw_ma, mto} <= 4'h8;
    #1 check({o_serr_n, o_serr_oe_n} === {2{~exp}}, "syserr pulse");
    axi_rd(OFS_REASON, d, r);
    check(d[ev] === exp, "reason bit");
    axi_rd(OFS_STATUS, d, r);
    check(d[0] === exp, "signaled bit");
    axi_wr(OFS_REASON, 32'h7f);
    axi_wr(OFS_STATUS, 32'h1);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Command reset value and an unmapped offset.
  task automatic s_regs();
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(OFS_CMD, d, r);
    check(d === 32'h0 && r === RESP_OKAY, "command reset");
    axi_rd(8'h1c, d, r);
    check(r === RESP_SLVERR, "unmapped offset");
    axi_wr(8'h1c, 32'h1);
  endtask
  // Secondary, posted-write abort and time-out causes, with enable, forward, mode and disable bits turned both ways.
  task automatic s_syserr();
    logic [31:0] d;
    logic [1:0]  r;
    cause(EV_PWTA, 1'b0);
    axi_wr(OFS_CMD, 32'h1);
    cause(EV_PWTA, 1'b1);
    cause(EV_SEC, 1'b0);
    axi_rd(OFS_SSTATUS, d, r);
    check(d[0] === 1'b1, "received bit");
    axi_wr(OFS_BCTL, 32'h1);
    cause(EV_SEC, 1'b1);
    cause(EV_PWMA, 1'b0);
    axi_wr(OFS_BCTL, 32'h3);
    cause(EV_PWMA, 1'b1);
    cause(EV_MTO, 1'b0);
    axi_wr(OFS_DISABLE, 32'h3e);
    cause(EV_PWTA, 1'b0);
    axi_wr(OFS_BCTL, 32'h7);
    cause(EV_MTO, 1'b1);
    axi_wr(OFS_DISABLE, 32'h0);
  endtask
  // Retry limit for each transfer kind: discard pulse and reason bit.
  task automatic s_retry();
    logic [31:0] d;
    logic [1:0]  r;
    for (int k = 0; k < 3; k++)
    begin
      @(posedge mclk);
      {rty, kind} <= {1'b1, k[1:0]};
      repeat (LIM) @(posedge mclk);
      rty <= 1'b0;
      #1 check(o_disc === 1'b1 && o_serr_n === 1'b0, "discard at limit");
      axi_rd(OFS_REASON, d, r);
      check(d[EV_PWRL + k] === 1'b1, "retry reason");
      axi_wr(OFS_REASON, 32'h7f);
    end
  endtask
  // Locked read with a busy secondary lock, then a normal or aborted end.
  task automatic s_lock(input logic ab, input logic pw);
    logic [31:0] d;
    logic [1:0]  r;
    int t;
    t = 0;
    @(posedge mclk);
    {f_abort, f_hold, p_frame_n, lrd_req} <= {ab, 3'h5};
    @(posedge mclk);
    {p_lock_n, p_frame_n, lrd_req, at_head} <= 4'h5;
    #1 check(o_retry_x === 1'b1 && o_no_pf === 1'b1, "retry crossing");
    repeat (5) @(posedge mclk);
    f_hold <= 1'b0;
    #1 check(o_bus_req === 1'b0, "waited for busy lock");
    while (o_bus_req !== 1'b1 && t < 40) begin @(posedge mclk); #1 t++; end
    check(o_sl_oe_n === 1'b0 && o_sl_n === 1'b1, "lock high in address");
    @(posedge mclk);
    #1 check(o_sl_n === 1'b0, "lock low after address");
    while ((ab ? o_tabort : ~o_retry_x) !== 1'b1 && t < 60) begin @(posedge mclk); #1 t++; end
    check(t < 60, "locked read end");
    @(posedge mclk);
    {p_lock_n, at_head, pw_pend} <= {2'h2, pw};
    repeat (2) @(posedge mclk);
    #1 check(o_sl_n === (ab || !pw), "lock kept until posted write ends");
    @(posedge mclk);
    {pw_pend, pw_end} <= 2'h1;
    @(posedge mclk);
    pw_end <= 1'b0;
    while ((o_sl_oe_n & ~o_tabort) !== 1'b1 && t < 80) begin @(posedge mclk); #1 t++; end
    check(t < 80 && o_retry_x === 1'b0, "lock released");
    axi_rd(OFS_LOCKSTAT, d, r);
    check(d[2:0] === 3'h0, "back to unlocked");
  endtask
  // ------------------------------------------------------------
  // Design, far side and run
  // ------------------------------------------------------------
  bridge_lock_and_syserr #(.RETRY_LIMIT(LIM)) bridge_lock_and_syserr_inst (
    .I_MCLK(mclk), .I_RST(rst), .I_AWADDR(awaddr), .I_AWVALID(awv), .O_AWREADY(o_awr),
    .I_WDATA(wdata), .I_WSTRB(4'hf), .I_WVALID(wv), .O_WREADY(o_wr), .O_BRESP(o_bresp),
    .O_BVALID(o_bv), .I_BREADY(brdy), .I_ARADDR(araddr), .I_ARVALID(arv), .O_ARREADY(o_arr),
    .O_RDATA(o_rdata), .O_RRESP(o_rresp), .O_RVALID(o_rv), .I_RREADY(rrdy),
    .I_SECONDARY_SYSERR_IN_N(sec_n), .O_PRIMARY_SYSERR_OUT_N(o_serr_n),
    .O_PRIMARY_SYSERR_OE_N(o_serr_oe_n), .I_PW_TABORT(pw_ta), .I_PW_MABORT(pw_ma),
    .I_MASTER_TIMEOUT(mto), .I_TGT_RETRY(rty), .I_XFER_DONE(1'b0), .I_XFER_KIND(kind),
    .O_DISCARD(o_disc), .I_P_LOCK_N(p_lock_n), .I_P_FRAME_N(p_frame_n),
    .I_S_LOCK_N(s_lock_n), .I_S_FRAME_N(s_frame_n), .I_S_IRDY_N(s_irdy_n),
    .I_LOCKED_RD_REQ(lrd_req), .I_LRD_AT_HEAD(at_head), .I_LRD_DONE(lrd_done),
    .I_LRD_ABORT(lrd_abort), .I_LOCK_PW_PENDING(pw_pend), .I_LOCK_PW_END(pw_end),
    .O_RETRY_CROSSING(o_retry_x), .O_LRD_BUS_REQ(o_bus_req), .O_LOCK_TABORT(o_tabort),
    .O_NO_PREFETCH(o_no_pf), .O_S_LOCK_OUT_N(o_sl_n), .O_S_LOCK_OE_N(o_sl_oe_n));
  pci_far_side pci_far_side_inst (
    .i_clk(mclk), .i_rst(rst), .i_hold(f_hold), .i_abort(f_abort), .i_bus_req(o_bus_req),
    .i_lock_out_n(o_sl_n), .i_lock_oe_n(o_sl_oe_n), .o_lock_n(s_lock_n),
    .o_frame_n(s_frame_n), .o_irdy_n(s_irdy_n), .o_done(lrd_done), .o_abort(lrd_abort));
  // Cut a hang short well past the expected length of the run.
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      failures++;
      complete_run();
    end
  end
  initial
  begin
    {mclk, rst, awv, wv, brdy, arv, rrdy, pw_ta, pw_ma, mto, rty} = 11'h200;
    {sec_n, p_lock_n, p_frame_n, lrd_req, at_head, f_hold, f_abort, pw_pend, pw_end} = 9'h1c0;
    {awaddr, araddr, wdata, kind} = 50'h0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    s_regs();
    s_syserr();
    s_retry();
    s_lock(1'b0, 1'b0);
    s_lock(1'b0, 1'b1);
    s_lock(1'b1, 1'b0);
    complete_run();
  end
endmodule

// file: dv/pci_far_side.sv
// Far side of the lock path: a rival secondary initiator and the locked target.
// Assumes the bench drives hold and abort at clock edges; the lock wire has a pull-up.
`timescale 1ns/10ps
module pci_far_side (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_hold,       // Rival initiator owns lock and bus.
  input  wire logic i_abort,      // Target aborts the locked read.
  input  wire logic i_bus_req,    // Address phase of the bridge's locked read.
  input  wire logic i_lock_out_n, // Bridge lock pin value.
  input  wire logic i_lock_oe_n,  // Bridge lock pin enable, low drives.
  output logic      o_lock_n,     // Resolved lock wire.
  output logic      o_frame_n,    // Secondary frame.
  output logic      o_irdy_n,     // Secondary initiator ready.
  output logic      o_done,       // Locked read data moved.
  output logic      o_abort       // Locked read aborted.
);
  logic [2:0] wait_r; // Target latency so the bridge sees a slow answer.
  logic       seen_r; // A locked read is outstanding; one answer per read.
  // ------------------------------------------------------------
  // Wires
  // ------------------------------------------------------------
  // The rival keeps lock and frame low; a released wire floats high.
  assign o_lock_n  = (i_lock_oe_n | i_lock_out_n) & ~i_hold;
  assign o_frame_n = ~i_hold;
  assign o_irdy_n  = ~i_hold;
  // ------------------------------------------------------------
  // Target
  // ------------------------------------------------------------
  // The request is a one-cycle address phase, so the read is latched
  // there and answered once, a few cycles later.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      {wait_r, seen_r, o_done, o_abort} <= 6'h00;
    else if (i_bus_req)
      {wait_r, seen_r, o_done, o_abort} <= 6'h04;
    else if (seen_r && wait_r == 3'h3)
      {wait_r, seen_r, o_done, o_abort} <= {4'h0, ~i_abort, i_abort};
    else
      {wait_r, o_done, o_abort} <= {wait_r + {2'h0, seen_r}, 2'h0};
  end
endmodule

// file: rtl/bridge_lock_and_syserr.sv
// Lock forwarding and system-error reporting for a PCI-to-PCI bridge.
// Assumes the forwarding engine reports transfer outcomes as one-cycle
// pulses and that all bus pins are synchronous to I_MCLK.
`timescale 1ns/10ps
module bridge_lock_and_syserr #(
  parameter int RETRY_LIMIT = bridge_pkg::RETRY_LIMIT_DEF
) (
  input  wire logic                          I_MCLK,
  input  wire logic                          I_RST,
  input  wire logic [bridge_pkg::AXI_AW-1:0] I_AWADDR,
  input  wire logic                          I_AWVALID,
  output logic                               O_AWREADY,
  input  wire logic [bridge_pkg::AXI_DW-1:0] I_WDATA,
  input  wire logic [3:0]                    I_WSTRB,
  input  wire logic                          I_WVALID,
  output logic                               O_WREADY,
  output logic [1:0]                         O_BRESP,
  output logic                               O_BVALID,
  input  wire logic                          I_BREADY,
  input  wire logic [bridge_pkg::AXI_AW-1:0] I_ARADDR,
  input  wire logic                          I_ARVALID,
  output logic                               O_ARREADY,
  output logic [bridge_pkg::AXI_DW-1:0]      O_RDATA,
  output logic [1:0]                         O_RRESP,
  output logic                               O_RVALID,
  input  wire logic                          I_RREADY,
  input  wire logic                          I_SECONDARY_SYSERR_IN_N,
  output logic                               O_PRIMARY_SYSERR_OUT_N,
  output logic                               O_PRIMARY_SYSERR_OE_N,
  input  wire logic                          I_PW_TABORT,
  input  wire logic                          I_PW_MABORT,
  input  wire logic                          I_MASTER_TIMEOUT,
  input  wire logic                          I_TGT_RETRY,
  input  wire logic                          I_XFER_DONE,
  input  wire logic [1:0]                    I_XFER_KIND,
  output logic                               O_DISCARD,
  input  wire logic                          I_P_LOCK_N,
  input  wire logic                          I_P_FRAME_N,
  input  wire logic                          I_S_LOCK_N,
  input  wire logic                          I_S_FRAME_N,
  input  wire logic                          I_S_IRDY_N,
  input  wire logic                          I_LOCKED_RD_REQ,
  input  wire logic                          I_LRD_AT_HEAD,
  input  wire logic                          I_LRD_DONE,
  input  wire logic                          I_LRD_ABORT,
  input  wire logic                          I_LOCK_PW_PENDING,
  input  wire logic                          I_LOCK_PW_END,
  output logic                               O_RETRY_CROSSING,
  output logic                               O_LRD_BUS_REQ,
  output logic                               O_LOCK_TABORT,
  output logic                               O_NO_PREFETCH,
  output logic                               O_S_LOCK_OUT_N,
  output logic                               O_S_LOCK_OE_N
);
  import bridge_pkg::*;

  // ----------------------------------------------------------------
  // Control and status state
  // ----------------------------------------------------------------
  logic           serr_en_r;     // Command: system-error enable.
  logic           sig_serr_r;    // Status: signaled system error.
  logic [2:0]     bctl_r;        // Bridge control bits.
  logic           rcv_serr_r;    // Secondary status: received error.
  logic [NEV-1:0] reason_r;      // Sticky cause of each system error.
  logic [NEV-1:0] dis_r;         // Per-event disable bits.
  logic [NEV-1:0] ev;            // Raw error causes this cycle.
  logic [NEV-1:0] fire;          // Causes that really raise the output.
  logic           serr_fire;     // Any cause fires this cycle.
  logic           discard;       // Retry limit reached on this retry.
  lock_st_t       st_r;          // Lock engine state.
  lock_st_t       st_nxt;        // Its next value.
  logic [24:0]    retry_cnt_r;   // Retries of the transfer at the head.
  logic           wr_go;         // A register write is taken now.
  logic [31:0]    wdata;         // Write data, masked by the low strobe.
  logic [7:0]     waddr_r;       // Captured write address.
  logic [7:0]     rd_addr;       // Read address.
  logic [31:0]    rd_val;        // Read mux output.
  logic           rd_hit;        // Read address is mapped.

  // ----------------------------------------------------------------
  // Retry limit counter
  // ----------------------------------------------------------------
  // The counter restarts whenever the head transfer finishes. The
  // discard pulse is the limit-th retry, so the width covers the limit.
  assign discard = I_TGT_RETRY && (retry_cnt_r == 25'(RETRY_LIMIT - 1));

  // Count retries of the head transfer and clear on completion.
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
      retry_cnt_r <= 25'h0;
    else if (I_XFER_DONE || discard)
      retry_cnt_r <= 25'h0;
    else if (I_TGT_RETRY)
      retry_cnt_r <= retry_cnt_r + 25'h1;
  end

  // Tell the queues to drop the head transfer.
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
      O_DISCARD <= 1'b0;
    else
      O_DISCARD <= discard;
  end

  // ----------------------------------------------------------------
  // System error causes and gating
  // ----------------------------------------------------------------
  // Each cause is gated by its own control; the enable in the command
  // register is a global gate over all of them.
  always_comb
  begin
    ev          = '0;
    ev[EV_SEC]  = !I_SECONDARY_SYSERR_IN_N;
    ev[EV_PWTA] = I_PW_TABORT;
    ev[EV_PWMA] = I_PW_MABORT;
    ev[EV_PWRL] = discard && (I_XFER_KIND == KIND_PW);
    ev[EV_DWRL] = discard && (I_XFER_KIND == KIND_DW);
    ev[EV_DRRL] = discard && (I_XFER_KIND == KIND_DR);
    ev[EV_MTO]  = I_MASTER_TIMEOUT;
    // Disable bits only exist for the causes in the mask.
    fire = ev & ~(dis_r & DIS_MASK);
    fire[EV_SEC] = ev[EV_SEC] && bctl_r[BCTL_FWD];
    fire[EV_PWMA] = fire[EV_PWMA] && bctl_r[BCTL_MAM];
    fire[EV_MTO] = ev[EV_MTO] && bctl_r[BCTL_MTO];
    fire = fire & {NEV{serr_en_r}};
  end

  assign serr_fire = |fire;

  // Drive the open-drain output low for one clock per cycle in which any cause fires.
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_PRIMARY_SYSERR_OUT_N <= 1'b1;
      O_PRIMARY_SYSERR_OE_N  <= 1'b1;
    end
    else
    begin
      O_PRIMARY_SYSERR_OUT_N <= !serr_fire;
      O_PRIMARY_SYSERR_OE_N  <= !serr_fire;
    end
  end

  // ----------------------------------------------------------------
  // Register bus write side
  // ----------------------------------------------------------------
  // Address and data are taken in the same cycle once both are
  // offered; the response follows one cycle later.
  assign wr_go = I_AWVALID && I_WVALID && !O_AWREADY && !O_BVALID;
  assign wdata = I_WSTRB[0] ? I_WDATA : 32'h0;

  // Handshake flops for the write channels.
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_AWREADY <= 1'b0;
      O_WREADY  <= 1'b0;
      O_BVALID  <= 1'b0;
      O_BRESP   <= RESP_OKAY;
      waddr_r   <= 8'h0;
    end
    else
    begin
      O_AWREADY <= wr_go;
      O_WREADY  <= wr_go;
      if (wr_go)
        waddr_r <= I_AWADDR;
      if (O_AWREADY)
      begin
        O_BVALID <= 1'b1;
        O_BRESP  <= (waddr_r <= OFS_LOCKSTAT && waddr_r[1:0] == 2'h0)
                    ? RESP_OKAY : RESP_SLVERR;
      end
      else if (I_BREADY)
        O_BVALID <= 1'b0;
    end
  end

  // Plain read-write control bits; writes land in the ready cycle.
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      serr_en_r <= 1'b0;
      bctl_r    <= 3'h0;
      dis_r     <= RST_DIS;
    end
    else if (O_AWREADY && I_WSTRB[0])
    begin
      if (I_AWADDR == OFS_CMD)
        serr_en_r <= I_WDATA[0];
      if (I_AWADDR == OFS_BCTL)
        bctl_r <= I_WDATA[2:0];
      if (I_AWADDR == OFS_DISABLE)
        dis_r <= I_WDATA[NEV-1:0] & DIS_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Sticky status bits, write one to clear, set wins
  // ----------------------------------------------------------------
  // Signaled and received error bits.
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      sig_serr_r <= 1'b0;
      rcv_serr_r <= 1'b0;
    end
    else
    begin
      if (serr_fire)
        sig_serr_r <= 1'b1;
      else if (O_AWREADY && I_AWADDR == OFS_STATUS && wdata[0])
        sig_serr_r <= 1'b0;
      if (ev[EV_SEC])
        rcv_serr_r <= 1'b1;
      else if (O_AWREADY && I_AWADDR == OFS_SSTATUS && wdata[0])
        rcv_serr_r <= 1'b0;
    end
  end

  // One reason bit per cause; only causes that fired are recorded.
  for (genvar g = 0; g < NEV; g++)
  begin : g_reason
    always_ff @(posedge I_MCLK or posedge I_RST)
    begin
      if (I_RST)
        reason_r[g] <= 1'b0;
      else if (fire[g])
        reason_r[g] <= 1'b1;
      else if (O_AWREADY && I_AWADDR == OFS_REASON && wdata[g])
        reason_r[g] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register bus read side
  // ----------------------------------------------------------------
  assign rd_addr = I_ARADDR;

  // Read mux; reserved bits read as zero.
  always_comb
  begin
    rd_val = 32'h0;
    rd_hit = 1'b1;
    case (rd_addr)
      OFS_CMD:      rd_val[0] = serr_en_r;
      OFS_STATUS:   rd_val[0] = sig_serr_r;
      OFS_BCTL:     rd_val[2:0] = bctl_r;
      OFS_SSTATUS:  rd_val[0] = rcv_serr_r;
      OFS_REASON:   rd_val[NEV-1:0] = reason_r;
      OFS_DISABLE:  rd_val[NEV-1:0] = dis_r;
      OFS_LOCKSTAT: rd_val[2:0] = st_r;
      default:      rd_hit = 1'b0;
    endcase
  end

  // Read handshake: data follows the address by one clock.
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_ARREADY <= 1'b0;
      O_RVALID  <= 1'b0;
      O_RDATA   <= 32'h0;
      O_RRESP   <= RESP_OKAY;
    end
    else
    begin
      O_ARREADY <= I_ARVALID && !O_ARREADY && !O_RVALID;
      if (I_ARVALID && !O_ARREADY && !O_RVALID)
      begin
        O_RVALID <= 1'b1;
        O_RDATA  <= rd_val;
        O_RRESP  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (I_RREADY)
        O_RVALID <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Lock engine
  // ----------------------------------------------------------------
  // Only a locked read from the primary side starts a sequence; the
  // secondary lock pin is never looked at for upstream requests, so
  // upstream traffic is always forwarded unlocked.
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      L_IDLE:
        if (I_LOCKED_RD_REQ)
          st_nxt = L_QUEUED;
      L_QUEUED:
        // Wait for earlier work to drain and for a free secondary lock.
        if (I_LRD_AT_HEAD && I_S_LOCK_N && I_S_FRAME_N && I_S_IRDY_N)
          st_nxt = L_ADDR;
      L_ADDR:
        st_nxt = L_RDLOCK;
      L_RDLOCK:
        if (I_LRD_ABORT)
          st_nxt = L_ABORT;
        else if (I_TGT_RETRY)
          st_nxt = L_QUEUED;
        else if (I_LRD_DONE)
          st_nxt = L_HELD;
      L_HELD:
        // Later retries leave the lock alone.
        if (I_MASTER_TIMEOUT)
          st_nxt = L_REL;
        else if (I_P_LOCK_N && I_P_FRAME_N)
          st_nxt = I_LOCK_PW_PENDING ? L_PWDRAIN : L_REL;
      L_PWDRAIN:
        if (I_LOCK_PW_END)
          st_nxt = L_REL;
      L_ABORT:
        // Abort is returned until the initiator lets lock go.
        if (I_P_LOCK_N && I_P_FRAME_N)
          st_nxt = L_IDLE;
      L_REL:
        st_nxt = L_IDLE;
      default:
        st_nxt = L_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
      st_r <= L_IDLE;
    else
      st_r <= st_nxt;
  end

  // Outputs decoded from the next state so they stand in the state.
  // The lock pin is driven high in the address phase, low while locked,
  // high for one release clock, and otherwise left undriven.
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_RETRY_CROSSING <= 1'b0;
      O_LRD_BUS_REQ    <= 1'b0;
      O_LOCK_TABORT    <= 1'b0;
      O_NO_PREFETCH    <= 1'b0;
      O_S_LOCK_OUT_N   <= 1'b1;
      O_S_LOCK_OE_N    <= 1'b1;
    end
    else
    begin
      O_RETRY_CROSSING <= st_nxt inside {L_QUEUED, L_ADDR, L_RDLOCK};
      O_LRD_BUS_REQ    <= st_nxt == L_ADDR;
      O_LOCK_TABORT    <= st_nxt == L_ABORT;
      O_NO_PREFETCH    <= st_nxt != L_IDLE;
      O_S_LOCK_OUT_N   <= !(st_nxt inside {L_RDLOCK, L_HELD, L_PWDRAIN});
      O_S_LOCK_OE_N    <= !(st_nxt inside {L_ADDR, L_RDLOCK, L_HELD, L_PWDRAIN, L_REL});
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RST);

  sequence s_addr_phase;
    !O_S_LOCK_OE_N && O_S_LOCK_OUT_N;
  endsequence

  sequence s_lock_on;
    !O_S_LOCK_OE_N && !O_S_LOCK_OUT_N;
  endsequence

  chk_serr_needs_enable: assert property (
    !O_PRIMARY_SYSERR_OUT_N |-> $past(serr_en_r))
    else $error("System error driven without enable.");

  chk_serr_sets_status: assert property (
    !O_PRIMARY_SYSERR_OUT_N |-> sig_serr_r)
    else $error("Signaled status not set with system error.");

  chk_sec_forward: assert property (
    !I_SECONDARY_SYSERR_IN_N && serr_en_r && bctl_r[BCTL_FWD]
    |=> !O_PRIMARY_SYSERR_OUT_N && reason_r[EV_SEC])
    else $error("Secondary error not forwarded.");

  chk_sec_received: assert property (
    !I_SECONDARY_SYSERR_IN_N |=> rcv_serr_r)
    else $error("Received error bit not set.");

  chk_mto_gate: assert property (
    I_MASTER_TIMEOUT && serr_en_r && !bctl_r[BCTL_MTO] && ev[EV_MTO:EV_SEC+1] == 6'h20
    && !discard && I_SECONDARY_SYSERR_IN_N |=> O_PRIMARY_SYSERR_OUT_N)
    else $error("Time-out raised error while its enable is clear.");

  chk_disable_mask: assert property (
    I_PW_TABORT && dis_r[EV_PWTA] |=> !reason_r[EV_PWTA] || $past(reason_r[EV_PWTA]))
    else $error("Disabled cause recorded.");

  chk_lock_sequence: assert property (
    $rose(O_LRD_BUS_REQ) |-> s_addr_phase ##1 s_lock_on)
    else $error("Lock not asserted one clock after address phase.");

  chk_retry_crossing: assert property (
    st_r == L_QUEUED |-> O_RETRY_CROSSING)
    else $error("Crossing request not retried while locked read queued.");

  chk_release_order: assert property (
    st_r == L_HELD && I_P_LOCK_N && I_P_FRAME_N && !I_MASTER_TIMEOUT
    && !I_LOCK_PW_PENDING |=> (O_S_LOCK_OUT_N && !O_S_LOCK_OE_N) ##1 O_S_LOCK_OE_N)
    else $error("Secondary lock not released after primary idle.");

endmodule

// file: rtl/bridge_pkg.sv
// Constants shared by the lock and system-error block of the bridge.
// Assumes a 32-bit AXI4-Lite register bus and one 100 MHz clock.
package bridge_pkg;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int          AXI_AW       = 8;       // Byte address width.
  localparam int          AXI_DW       = 32;      // Data width.
  localparam logic [7:0]  OFS_CMD      = 8'h00;   // Command: system-error enable.
  localparam logic [7:0]  OFS_STATUS   = 8'h04;   // Status: signaled system error.
  localparam logic [7:0]  OFS_BCTL     = 8'h08;   // Bridge control bits.
  localparam logic [7:0]  OFS_SSTATUS  = 8'h0c;   // Secondary status: received error.
  localparam logic [7:0]  OFS_REASON   = 8'h10;   // Cause of each system error.
  localparam logic [7:0]  OFS_DISABLE  = 8'h14;   // Per-event disable bits.
  localparam logic [7:0]  OFS_LOCKSTAT = 8'h18;   // Lock engine state.
  localparam logic [1:0]  RESP_OKAY    = 2'h0;    // Normal answer.
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;    // Answer to an unmapped address.

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BCTL_FWD  = 0;                   // Forward secondary error input.
  localparam int BCTL_MAM  = 1;                   // Master abort mode.
  localparam int BCTL_MTO  = 2;                   // Master time-out error enable.
  localparam int NEV       = 7;                   // Number of error causes.
  localparam int EV_SEC    = 0;                   // Secondary error input.
  localparam int EV_PWTA   = 1;                   // Posted write target abort.
  localparam int EV_PWMA   = 2;                   // Posted write master abort.
  localparam int EV_PWRL   = 3;                   // Posted write retry limit.
  localparam int EV_DWRL   = 4;                   // Delayed write retry limit.
  localparam int EV_DRRL   = 5;                   // Delayed read retry limit.
  localparam int EV_MTO    = 6;                   // Master time-out.
  localparam logic [NEV-1:0] DIS_MASK = 7'h3e;    // Causes that own a disable bit.
  localparam logic [NEV-1:0] RST_DIS  = 7'h00;    // Disable bits after reset.

  // ----------------------------------------------------------------
  // Transfer kinds and retry limit
  // ----------------------------------------------------------------
  localparam logic [1:0] KIND_PW = 2'h0;          // Posted write.
  localparam logic [1:0] KIND_DW = 2'h1;          // Delayed write.
  localparam logic [1:0] KIND_DR = 2'h2;          // Delayed read.
  localparam int         RETRY_LIMIT_DEF = 2**24; // Retries before discard.

  // Lock engine states.
  typedef enum logic [2:0] {
    L_IDLE, L_QUEUED, L_ADDR, L_RDLOCK, L_HELD, L_PWDRAIN, L_ABORT, L_REL
  } lock_st_t;

endpackage
